/* rtl/bmrs_consts.vh */
// constants for the boot mode and reset select block
`ifndef BMRS_CONSTS_VH
`define BMRS_CONSTS_VH
// boot mode encodings
`define BMRS_MODE_NONE 2'h0
`define BMRS_MODE_EPROM 2'h1
`define BMRS_MODE_HOST 2'h2
`define BMRS_MODE_BAD 2'h3
// eprom data width in bits
`define BMRS_EPROM_WIDTH 8
// reset vector default
`define BMRS_RESET_VECTOR 24'h020004
// reset sequencer states
`define BMRS_ST_RESET 2'h0
`define BMRS_ST_SAMPLE 2'h1
`define BMRS_ST_RUN 2'h2
// last count of the settle wait, synchroniser plus filter depth
`define BMRS_SETTLE_LAST 3'h3
`endif

/* rtl/bmrs_sync.v */
// three stage synchroniser for pin inputs with agreement filter
`timescale 1ns/1ns
module bmrs_sync #(
  parameter WIDTH = 3
) (
  input wire clk,
  input wire reset_n,
  input wire [WIDTH-1:0] din,
  output reg [WIDTH-1:0] dout
);
  reg [WIDTH-1:0] s1_r;
  reg [WIDTH-1:0] s2_r;
  reg [WIDTH-1:0] s3_r;
  genvar i;

  // first stage feeds only the second stage
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s1_r <= {WIDTH{1'b0}};
      s2_r <= {WIDTH{1'b0}};
      s3_r <= {WIDTH{1'b0}};
    end else begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // output changes only when stages two and three agree
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          dout[i] <= 1'b0;
        end else if (s2_r[i] == s3_r[i]) begin
          dout[i] <= s3_r[i];
        end
      end
    end
  endgenerate
endmodule // bmrs_sync

/* rtl/bmrs_boot_select.v */
// boot strap decode, boot memory select pin control and reset entry
// Behaviour
// - eprom select high, link low: eprom boot, drive select
// - straps low, select pin high: host boot
// - straps low, select pin low: no boot, external
// - one instruction per input clock period
// - reset gives known state, start at vector
// - eprom boot uses eight bit wide eprom
// - select pin drives only in eprom mode, master
//
// overview
// three strap levels pick one of three boot modes
// eprom mode: select pin becomes the eprom chip select on the bus master
// host mode: select pin is only an input strap
// no boot: core runs straight from external memory
// link strap high is not a supported board setting
// it is flagged on strap_error and the core stays halted
//
// timing after reset release
// edge 1: sequencer leaves reset state, settle count starts
// edges 1 to 3: synchroniser fills, edge 4: agreement filter settles
// edge 5: filtered straps decoded into the held mode
// edge 6: mode, run and select pin enable outputs update
//
// hazards and limits
// straps must stand still from reset until edge 5
// a strap change after capture is ignored until next reset
// select pin enable follows bus ownership one clock late
// select pin value mirrors the chip select request one clock late
// test reset level is filtered like any other pin
// a reset pulse shorter than one clock still clears all state
//
`timescale 1ns/1ns
`include "bmrs_consts.vh"
module bmrs_boot_select #(
  parameter VEC_W = 24,
  parameter [VEC_W-1:0] RESET_VECTOR = `BMRS_RESET_VECTOR
) (
  input wire clk,
  input wire reset_n,
  input wire test_reset_n,
  input wire eprom_boot_select,
  input wire link_boot_strap,
  input wire boot_memory_select_n_i,
  input wire bus_master,
  input wire eprom_cs_req,
  output reg boot_memory_select_n_o,
  output reg boot_memory_select_n_oe,
  output reg [1:0] boot_mode,
  output reg [3:0] eprom_width,
  output reg core_run,
  output reg instr_tick,
  output reg [VEC_W-1:0] start_addr,
  output reg test_logic_ready,
  output reg strap_error
);
  localparam ST_RESET = `BMRS_ST_RESET;
  localparam ST_SAMPLE = `BMRS_ST_SAMPLE;
  localparam ST_RUN = `BMRS_ST_RUN;
  localparam [3:0] EPROM_W = `BMRS_EPROM_WIDTH;

  localparam [2:0] SETTLE_LAST = `BMRS_SETTLE_LAST;

  wire [3:0] pins_sync;
  wire settled;
  wire running;
  wire valid_mode;
  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [2:0] settle_r;
  reg [2:0] settle_nxt;
  reg [1:0] mode_r;

  // decode of the three strap levels into a boot mode
  function [1:0] bmrs_decode;
    input eb;
    input lb;
    input boot_memory_select_n;
    begin
      if (lb)
        bmrs_decode = `BMRS_MODE_BAD;
      else if (eb)
        bmrs_decode = `BMRS_MODE_EPROM;
      else if (boot_memory_select_n)
        bmrs_decode = `BMRS_MODE_HOST;
      else
        bmrs_decode = `BMRS_MODE_NONE;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // straps are pins, so they cross into the clock domain first
  // test reset is a pin too, so it shares the synchroniser
  bmrs_sync #(
    .WIDTH(4)
  ) u_sync (
    .clk(clk),
    .reset_n(reset_n),
    .din({eprom_boot_select, link_boot_strap, boot_memory_select_n_i, test_reset_n}),
    .dout(pins_sync)
  );

  ////////////////////////////////////////////////////////////////////////
  // settle count reaches its end once the filter output is trustworthy
  assign settled = (settle_r == SETTLE_LAST);
  assign running = (state_r == ST_RUN);
  assign valid_mode = (mode_r != `BMRS_MODE_BAD);

  // reset sequencer: wait for synchroniser to fill, sample, then run
  always @* begin
    state_nxt = state_r;
    settle_nxt = settle_r;
    case (state_r)
      ST_RESET: begin
        state_nxt = ST_SAMPLE;
        settle_nxt = 3'h0;
      end
      ST_SAMPLE: begin
        if (settled) begin
          state_nxt = ST_RUN;
        end else begin
          settle_nxt = settle_r + 3'h1;
        end
      end
      ST_RUN: begin
        state_nxt = ST_RUN;
      end
      default: begin
        state_nxt = ST_RESET;
        settle_nxt = 3'h0;
      end
    endcase
  end

  // capturing earlier would latch the empty synchroniser, i.e. no boot
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= ST_RESET;
      settle_r <= 3'h0;
      mode_r <= `BMRS_MODE_NONE;
    end else begin
      state_r <= state_nxt;
      settle_r <= settle_nxt;
      if ((state_r == ST_SAMPLE) && settled) begin
        // mode frozen once running, until the next reset
        mode_r <= bmrs_decode(pins_sync[3], pins_sync[2], pins_sync[1]);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // mode report and strap fault flag
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      boot_mode <= `BMRS_MODE_NONE;
      strap_error <= 1'b0;
      eprom_width <= 4'h0;
    end else begin
      boot_mode <= mode_r;
      strap_error <= running && !valid_mode;
      eprom_width <= (mode_r == `BMRS_MODE_EPROM) ? EPROM_W : 4'h0;
    end
  end

  // select pin: chip select for the eprom, released in other modes
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      boot_memory_select_n_o <= 1'b1;
      boot_memory_select_n_oe <= 1'b0;
    end else begin
      // only the bus master may drive, slaves leave the pin floating
      boot_memory_select_n_oe <= running &&
        (mode_r == `BMRS_MODE_EPROM) && bus_master;
      boot_memory_select_n_o <= ~eprom_cs_req;
    end
  end

  // core start: halted on a bad strap rather than running blind
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      core_run <= 1'b0;
      instr_tick <= 1'b0;
      start_addr <= {VEC_W{1'b0}};
    end else begin
      core_run <= running && valid_mode;
      start_addr <= RESET_VECTOR;
      // one instruction slot every clock, no divider
      instr_tick <= running && valid_mode;
    end
  end

  // test logic ready follows the filtered test reset level
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      test_logic_ready <= 1'b0;
    end else begin
      test_logic_ready <= pins_sync[0];
    end
  end
endmodule // bmrs_boot_select

/* tb/bmrs_board.sv */
// board strapping and boot pin model
`timescale 1ns/1ns
module bmrs_board(
  input wire logic [1:0] sel,
  input wire logic oe,
  input wire logic o,
  output logic eb,
  output logic lb,
  output logic pin
);
  // straps are hardwired, link strap high only as a deliberate fault
  assign eb = sel == 2'h1;
  assign lb = sel == 2'h3;
  // device drives pin when enabled, else the strap level shows
  assign pin = oe ? o : sel == 2'h2;
endmodule // bmrs_board

/* tb/bmrs_monitor.sv */
// checker for the boot mode select ports
`timescale 1ns/1ns
module bmrs_monitor(
  input wire clk,
  input wire reset_n,
  input wire eprom_boot_select,
  input wire boot_memory_select_n_i,
  input wire bus_master,
  input wire eprom_cs_req,
  input wire boot_memory_select_n_o,
  input wire boot_memory_select_n_oe,
  input wire [1:0] boot_mode,
  input wire [3:0] eprom_width,
  input wire core_run,
  input wire instr_tick,
  input wire [23:0] start_addr
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  AST_TICK: assert property (instr_tick == core_run) else $error("tick");
  AST_WIDTH: assert property ((boot_mode == 2'h1) == (eprom_width == 4'h8)) else $error("width");
  AST_MODE: assert property ($rose(core_run) |-> boot_mode == (eprom_boot_select ? 2'h1 :
    {boot_memory_select_n_i, 1'b0})) else $error("mode");
  AST_OE: assert property (boot_memory_select_n_oe |-> boot_mode == 2'h1 && $past(bus_master)) else $error("oe");
  AST_DRIVE: assert property (core_run && boot_mode == 2'h1 && bus_master |=> boot_memory_select_n_oe) else $error("drv");
  AST_HOLD: assert property (core_run |=> core_run && $stable(boot_mode)) else $error("hold");
  AST_ADDR: assert property ($rose(core_run) |-> start_addr == 24'h020004) else $error("addr");
  AST_IDLE: assert property (!core_run |-> !boot_memory_select_n_oe) else $error("idle");
  AST_CS: assert property (core_run |-> boot_memory_select_n_o == !$past(eprom_cs_req)) else $error("cs");
  // main scenarios reached
  C_OE: cover property (boot_memory_select_n_oe);
  C_HOST: cover property (core_run && boot_mode == 2'h2);
  C_EXT: cover property (core_run && boot_mode == 2'h0);
endmodule // bmrs_monitor
bind bmrs_boot_select bmrs_monitor mon_u(.*);

/* tb/bmrs_boot_select_test.sv */
// self-checking bench for boot mode select
`timescale 1ns/1ns
module bmrs_boot_select_test;
  logic clk = 0, reset_n = 0, trst_n = 0, bm = 0, req = 0, o, oe, run, tk, tlr, err, eb, lb, pin;
  logic [1:0] sel = 0, mode;
  logic [3:0] w;
  logic [23:0] sa;
  logic [5:0] q[$];
  int fails = 0, total_checks = 0;
  always #5 clk = ~clk;
  bmrs_board brd_u(.sel(sel), .oe(oe), .o(o), .eb(eb), .lb(lb), .pin(pin));
  bmrs_boot_select dut_u(.clk(clk), .reset_n(reset_n), .test_reset_n(trst_n),
    .eprom_boot_select(eb), .link_boot_strap(lb), .boot_memory_select_n_i(pin),
    .bus_master(bm), .eprom_cs_req(req), .boot_memory_select_n_o(o),
    .boot_memory_select_n_oe(oe), .boot_mode(mode), .eprom_width(w), .core_run(run),
    .instr_tick(tk), .start_addr(sa), .test_logic_ready(tlr), .strap_error(err));
  task chk(string n, logic [23:0] s, logic [23:0] e);
    total_checks++;
    if (s !== e) begin
      fails++;
      $display("CHECK FAILED %s exp %h seen %h", n, e, s);
    end
  endtask
  task end_of_test;
    if (fails == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // result watcher, one note per reset
  always @(posedge clk) if (reset_n && (run | err) && q.size() > 0) begin
    chk("mode", mode, q[0][5:4]);
    chk("width", w, q[0][3:0]);
    chk("addr", sa, 24'h020004);
    chk("run", run, q[0][5:4] != 2'h3);
    chk("tick", tk, q[0][5:4] != 2'h3);
    chk("err", err, q[0][5:4] == 2'h3);
    void'(q.pop_front());
  end
  // each strap setting in turn, random bus traffic from the first edge after reset release
  initial begin
    void'($urandom(76));
    for (int i = 0; i < 4; i++) begin
      sel <= i[1:0];
      reset_n <= 0;
      trst_n <= 0;
      repeat (6) @(posedge clk);
      reset_n <= 1;
      trst_n <= 1;
      q.push_back({i[1:0], i == 1 ? 4'h8 : 4'h0});
      repeat (30) begin
        @(posedge clk);
        bm <= $urandom;
        req <= $urandom;
      end
      chk("popped", q.size(), 24'h0);
      // late strap change must be ignored
      sel <= $urandom;
      repeat (4) @(posedge clk);
      chk("held", mode, i[1:0]);
      chk("tlr", tlr, 24'h1);
    end
    end_of_test;
  end
  initial begin
    #5000;
    fails++;
    end_of_test;
  end
endmodule // bmrs_boot_select_test
